// file: design/sae_defines.svh
`ifndef SAE_DEFINES_SVH
`define SAE_DEFINES_SVH

// Register page that holds the translation registers (page 21)
`define SAE_MMU_PAGE        8'h15

// Register offsets within the register file
`define SAE_OFS_PAGE0       8'hf0
`define SAE_OFS_PAGE_REMAP0 8'he0
`define SAE_OFS_CSR         8'hf4
`define SAE_OFS_MODE        8'hf6
`define SAE_OFS_ISR         8'hf8
`define SAE_OFS_DMA_SEG     8'hf9

// Field positions in ext_mode_reg_2
`define SAE_MODE_REMAP_BIT  5
`define SAE_MODE_SAVE_BIT   6

// Reset values
`define SAE_CSR_RESET       6'h00
`define SAE_MODE_RESET      1'b0

// Widths
`define SAE_SEG_W           6
`define SAE_PAGE_W          8
`define SAE_VA_W            16
`define SAE_PA_W            22
`define SAE_PAGE_OFS_W      14
`define SAE_REG_W           8
`define SAE_DEPTH_W         4

`endif

// file: design/sae_pkg.sv
package sae_pkg;

  // Kind of memory access presented for translation
  typedef enum logic [2:0] {
    ACC_FETCH,
    ACC_VECTOR,
    ACC_DATA,
    ACC_PROG_DATA,
    ACC_DMA
  } sae_acc_type;

  // Register selected by a register-file access
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_PAGE,
    SEL_CSR,
    SEL_MODE,
    SEL_ISR,
    SEL_DMA_SEG
  } sae_sel_type;

endpackage : sae_pkg

// file: design/sae_page_mem.sv
`timescale 1ns/1ps
`include "sae_defines.svh"

module sae_page_mem (
  // Clock and control
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     ce_i,
  // Write port
  input  wire logic                     wr_en_i,
  input  wire logic [1:0]               wr_idx_i,
  input  wire logic [`SAE_PAGE_W-1:0]   wr_data_i,
  // Read port A (translation)
  input  wire logic [1:0]               rd_a_idx_i,
  output logic      [`SAE_PAGE_W-1:0]   rd_a_data_o,
  // Read port B (register reads)
  input  wire logic [1:0]               rd_b_idx_i,
  output logic      [`SAE_PAGE_W-1:0]   rd_b_data_o
);

  logic [`SAE_PAGE_W-1:0] mem_q [4];
  logic [`SAE_PAGE_W-1:0] mem_d [4];
  logic [`SAE_PAGE_W-1:0] rd_a_d;
  logic [`SAE_PAGE_W-1:0] rd_b_d;

  // Page words have no reset: contents stay unknown until software loads them
  for (genvar i = 0; i < 4; i++) begin : g_entry
    assign mem_d[i] = (ce_i && wr_en_i && wr_idx_i == 2'(i)) ? wr_data_i : mem_q[i];
    always_ff @(posedge clk_i) begin
      mem_q[i] <= mem_d[i];
    end
  end

  always_comb begin
    rd_a_d = ce_i ? mem_q[rd_a_idx_i] : rd_a_data_o;
    rd_b_d = ce_i ? mem_q[rd_b_idx_i] : rd_b_data_o;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_a_data_o <= '0;
      rd_b_data_o <= '0;
    end else begin
      rd_a_data_o <= rd_a_d;
      rd_b_data_o <= rd_b_d;
    end
  end

endmodule : sae_page_mem

// file: design/sae_top.sv
`timescale 1ns/1ps
`include "sae_defines.svh"

module sae_top (
  // Clock, reset, enable
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       ce_i,
  // Register file access
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  input  wire logic [7:0]                 reg_addr_i,
  input  wire logic [7:0]                 reg_page_i,
  input  wire logic [`SAE_REG_W-1:0]      reg_wdata_i,
  output logic      [`SAE_REG_W-1:0]      reg_rdata_o,
  output logic                            reg_rvalid_o,
  // Mode state
  output logic                            page_reg_remap_o,
  output logic                            code_seg_save_enable_o,
  output logic                            service_active_o,
  // Core control-flow events
  input  wire logic                       irq_entry_i,
  input  wire logic                       iret_i,
  input  wire logic                       far_load_i,
  input  wire logic [`SAE_SEG_W-1:0]      far_seg_i,
  input  wire logic                       csr_restore_i,
  input  wire logic [`SAE_SEG_W-1:0]      csr_restore_data_i,
  output logic                            csr_push_o,
  output logic      [`SAE_SEG_W-1:0]      csr_push_data_o,
  // Address translation
  input  wire logic                       acc_valid_i,
  input  wire sae_pkg::sae_acc_type       acc_kind_i,
  input  wire logic [`SAE_VA_W-1:0]       vaddr_i,
  input  wire logic                       dma_segment_select_i,
  output logic      [`SAE_PA_W-1:0]       paddr_o,
  output logic                            paddr_valid_o
);

  // Register decode, shared by the write and the read path
  function automatic sae_pkg::sae_sel_type reg_decode(
    input logic [7:0] addr,
    input logic [7:0] page,
    input logic       remap
  );
    sae_pkg::sae_sel_type sel;
    sel = sae_pkg::SEL_NONE;
    if (remap && addr[7:2] == 6'(`SAE_OFS_PAGE_REMAP0 >> 2)) begin
      sel = sae_pkg::SEL_PAGE;
    end else if (page == `SAE_MMU_PAGE) begin
      if (!remap && addr[7:2] == 6'(`SAE_OFS_PAGE0 >> 2)) begin
        sel = sae_pkg::SEL_PAGE;
      end else if (addr == `SAE_OFS_CSR) begin
        sel = sae_pkg::SEL_CSR;
      end else if (addr == `SAE_OFS_MODE) begin
        sel = sae_pkg::SEL_MODE;
      end else if (addr == `SAE_OFS_ISR) begin
        sel = sae_pkg::SEL_ISR;
      end else if (addr == `SAE_OFS_DMA_SEG) begin
        sel = sae_pkg::SEL_DMA_SEG;
      end
    end
    return sel;
  endfunction : reg_decode

  // Segment and mode registers
  logic [`SAE_SEG_W-1:0]   csr_q;
  logic [`SAE_SEG_W-1:0]   csr_d;
  logic [`SAE_SEG_W-1:0]   isr_q;
  logic [`SAE_SEG_W-1:0]   isr_d;
  logic [`SAE_SEG_W-1:0]   dma_seg_q;
  logic [`SAE_SEG_W-1:0]   dma_seg_d;
  logic                    remap_q;
  logic                    remap_d;
  logic                    save_en_q;
  logic                    save_en_d;
  logic [`SAE_DEPTH_W-1:0] depth_q;
  logic [`SAE_DEPTH_W-1:0] depth_d;
  logic                    push_q;
  logic                    push_d;
  logic [`SAE_SEG_W-1:0]   push_data_q;
  logic [`SAE_SEG_W-1:0]   push_data_d;
  logic                    active_q;
  logic                    active_d;

  sae_pkg::sae_sel_type    sel;
  logic                    wr_hit;
  logic                    compat_service;

  assign sel            = reg_decode(reg_addr_i, reg_page_i, remap_q);
  assign wr_hit         = reg_wr_i && sel != sae_pkg::SEL_NONE;
  // Interrupt segment stands in for the code segment while a compatible-mode service runs
  assign compat_service = depth_q != '0 && !save_en_q;

  always_comb begin
    csr_d       = csr_q;
    isr_d       = isr_q;
    dma_seg_d   = dma_seg_q;
    remap_d     = remap_q;
    save_en_d   = save_en_q;
    depth_d     = depth_q;
    push_d      = 1'b0;
    push_data_d = push_data_q;
    if (wr_hit) begin
      case (sel)
        sae_pkg::SEL_CSR: begin
          csr_d = reg_wdata_i[`SAE_SEG_W-1:0];
        end
        sae_pkg::SEL_MODE: begin
          remap_d   = reg_wdata_i[`SAE_MODE_REMAP_BIT];
          save_en_d = reg_wdata_i[`SAE_MODE_SAVE_BIT];
        end
        sae_pkg::SEL_ISR: begin
          isr_d = reg_wdata_i[`SAE_SEG_W-1:0];
        end
        sae_pkg::SEL_DMA_SEG: begin
          dma_seg_d = reg_wdata_i[`SAE_SEG_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Restore from the stack only matters when the frame carries a segment
    if (csr_restore_i && save_en_q) begin
      csr_d = csr_restore_data_i;
    end
    if (far_load_i) begin
      csr_d = far_seg_i;
    end
    if (iret_i && depth_q != '0) begin
      depth_d = depth_q - `SAE_DEPTH_W'(1);
    end
    if (irq_entry_i) begin
      if (depth_q != '1) begin
        depth_d = depth_q + `SAE_DEPTH_W'(1);
      end
      if (save_en_q) begin
        push_d      = 1'b1;
        push_data_d = csr_q;
        csr_d       = isr_q;
      end
      // Compatible mode: frame is counter and flags only, no push request
    end
    active_d = depth_d != '0;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      csr_q       <= `SAE_CSR_RESET;
      remap_q     <= `SAE_MODE_RESET;
      save_en_q   <= `SAE_MODE_RESET;
      depth_q     <= '0;
      push_q      <= 1'b0;
      push_data_q <= '0;
      active_q    <= 1'b0;
    end else if (ce_i) begin
      csr_q       <= csr_d;
      remap_q     <= remap_d;
      save_en_q   <= save_en_d;
      depth_q     <= depth_d;
      push_q      <= push_d;
      push_data_q <= push_data_d;
      active_q    <= active_d;
    end
  end

  // Interrupt and DMA segments carry no reset on purpose
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      isr_q   <= isr_d;
      dma_seg_q <= dma_seg_d;
    end
  end

  // Data page registers
  logic [`SAE_PAGE_W-1:0] page_rd_a;
  logic [`SAE_PAGE_W-1:0] page_rd_b;

  sae_page_mem u_page_mem (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .ce_i        (ce_i),
    .wr_en_i     (wr_hit && sel == sae_pkg::SEL_PAGE),
    .wr_idx_i    (reg_addr_i[1:0]),
    .wr_data_i   (reg_wdata_i),
    .rd_a_idx_i  (vaddr_i[`SAE_VA_W-1:`SAE_VA_W-2]),
    .rd_a_data_o (page_rd_a),
    .rd_b_idx_i  (reg_addr_i[1:0]),
    .rd_b_data_o (page_rd_b)
  );

  // Register read: two-cycle answer so page words come out of the memory register
  logic                    rd1_q;
  logic                    rd1_d;
  sae_pkg::sae_sel_type    rd1_sel_q;
  sae_pkg::sae_sel_type    rd1_sel_d;
  logic [`SAE_REG_W-1:0]   rd1_val_q;
  logic [`SAE_REG_W-1:0]   rd1_val_d;
  logic [`SAE_REG_W-1:0]   rdata_d;
  logic                    rvalid_d;

  always_comb begin
    rd1_d     = reg_rd_i && sel != sae_pkg::SEL_NONE;
    rd1_sel_d = sel;
    rd1_val_d = '0;
    case (sel)
      sae_pkg::SEL_CSR: begin
        rd1_val_d = {2'b00, csr_q};
      end
      sae_pkg::SEL_MODE: begin
        rd1_val_d[`SAE_MODE_REMAP_BIT] = remap_q;
        rd1_val_d[`SAE_MODE_SAVE_BIT]  = save_en_q;
      end
      sae_pkg::SEL_ISR: begin
        rd1_val_d = {2'b00, isr_q};
      end
      sae_pkg::SEL_DMA_SEG: begin
        rd1_val_d = {2'b00, dma_seg_q};
      end
      default: begin
        rd1_val_d = '0;
      end
    endcase
    rvalid_d = rd1_q;
    rdata_d  = reg_rdata_o;
    if (rd1_q) begin
      rdata_d = (rd1_sel_q == sae_pkg::SEL_PAGE) ? page_rd_b : rd1_val_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd1_q        <= 1'b0;
      rd1_sel_q    <= sae_pkg::SEL_NONE;
      rd1_val_q    <= '0;
      reg_rdata_o  <= '0;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      rd1_q        <= rd1_d;
      rd1_sel_q    <= rd1_sel_d;
      rd1_val_q    <= rd1_val_d;
      reg_rdata_o  <= rdata_d;
      reg_rvalid_o <= rvalid_d;
    end
  end

  // Address translation, two stages
  logic                    s1_valid_q;
  logic                    s1_valid_d;
  logic                    s1_paged_q;
  logic                    s1_paged_d;
  logic [`SAE_SEG_W-1:0]   s1_seg_q;
  logic [`SAE_SEG_W-1:0]   s1_seg_d;
  logic [`SAE_VA_W-1:0]    s1_va_q;
  logic [`SAE_VA_W-1:0]    s1_va_d;
  logic [`SAE_PA_W-1:0]    paddr_d;

  always_comb begin
    s1_valid_d = acc_valid_i;
    s1_va_d    = vaddr_i;
    s1_paged_d = 1'b0;
    s1_seg_d   = csr_q;
    case (acc_kind_i)
      sae_pkg::ACC_FETCH, sae_pkg::ACC_PROG_DATA: begin
        s1_seg_d = compat_service ? isr_q : csr_q;
      end
      sae_pkg::ACC_VECTOR: begin
        s1_seg_d = isr_q;
      end
      sae_pkg::ACC_DMA: begin
        s1_seg_d = dma_segment_select_i ? dma_seg_q : isr_q;
      end
      sae_pkg::ACC_DATA: begin
        // Paging ignores service state and save mode
        s1_paged_d = 1'b1;
      end
      default: begin
        s1_seg_d = csr_q;
      end
    endcase
    paddr_d = s1_paged_q ? {page_rd_a, s1_va_q[`SAE_PAGE_OFS_W-1:0]}
                         : {s1_seg_q, s1_va_q};
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_valid_q    <= 1'b0;
      s1_paged_q    <= 1'b0;
      s1_seg_q      <= '0;
      s1_va_q       <= '0;
      paddr_o       <= '0;
      paddr_valid_o <= 1'b0;
    end else if (ce_i) begin
      s1_valid_q    <= s1_valid_d;
      s1_paged_q    <= s1_paged_d;
      s1_seg_q      <= s1_seg_d;
      s1_va_q       <= s1_va_d;
      paddr_o       <= s1_valid_q ? paddr_d : paddr_o;
      paddr_valid_o <= s1_valid_q;
    end
  end

  // Mode and stacking outputs, all registered
  always_comb begin
    page_reg_remap_o       = remap_q;
    code_seg_save_enable_o = save_en_q;
    service_active_o       = active_q;
    csr_push_o             = push_q;
    csr_push_data_o        = push_data_q;
  end

endmodule : sae_top

// file: test/sae_props.sv
`timescale 1ns/1ps
module sae_props (
  // Clock and reset
  input wire logic                 clk_i,
  input wire logic                 sys_rst_i,
  // Register side
  input wire logic                 reg_wr_i,
  input wire logic [7:0]           reg_addr_i,
  input wire logic [7:0]           reg_page_i,
  input wire logic [7:0]           reg_rdata_o,
  input wire logic                 reg_rvalid_o,
  // Mode and events
  input wire logic                 page_reg_remap_o,
  input wire logic                 code_seg_save_enable_o,
  input wire logic                 service_active_o,
  input wire logic                 irq_entry_i,
  input wire logic                 csr_push_o,
  // Translation
  input wire logic                 acc_valid_i,
  input wire sae_pkg::sae_acc_type acc_kind_i,
  input wire logic [15:0]          vaddr_i,
  input wire logic [21:0]          paddr_o,
  input wire logic                 paddr_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_entry_save;
    irq_entry_i && code_seg_save_enable_o;
  endsequence
  sequence s_entry_compat;
    irq_entry_i && !code_seg_save_enable_o;
  endsequence

  property p_acc_lat;
    acc_valid_i |-> ##2 paddr_valid_o;
  endproperty
  a_acc_lat: assert property (p_acc_lat) else $error("translation answer not two cycles on");
  property p_seg_low;
    acc_valid_i && acc_kind_i != sae_pkg::ACC_DATA |-> ##2 paddr_o[15:0] == $past(vaddr_i, 2);
  endproperty
  a_seg_low: assert property (p_seg_low) else $error("segment offset bits wrong");
  property p_page_low;
    acc_valid_i && acc_kind_i == sae_pkg::ACC_DATA |-> ##2 paddr_o[13:0] == $past(vaddr_i[13:0], 2);
  endproperty
  a_page_low: assert property (p_page_low) else $error("page offset bits wrong");
  property p_push;
    s_entry_save |=> csr_push_o;
  endproperty
  a_push: assert property (p_push) else $error("no code segment push on entry");
  property p_no_push;
    s_entry_compat |=> !csr_push_o;
  endproperty
  a_no_push: assert property (p_no_push) else $error("push in default interrupt mode");
  property p_svc;
    irq_entry_i |=> service_active_o;
  endproperty
  a_svc: assert property (p_svc) else $error("service state not entered");
  property p_rst;
    $fell(sys_rst_i) |-> paddr_o == 22'h000000 && !csr_push_o && !code_seg_save_enable_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_resv;
    reg_rvalid_o && $past(reg_addr_i, 2) inside {8'hf8, 8'hf9} && $past(reg_page_i, 2) == 8'h15
      |-> reg_rdata_o[7:6] == 2'b00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved segment bits read nonzero");
  property p_remap;
    !$stable(page_reg_remap_o) |-> $past(reg_wr_i);
  endproperty
  a_remap: assert property (p_remap) else $error("remap moved without a write");
endmodule : sae_props

bind sae_top sae_props chk_u (.clk_i, .sys_rst_i, .reg_wr_i, .reg_addr_i, .reg_page_i, .reg_rdata_o,
  .reg_rvalid_o, .page_reg_remap_o, .code_seg_save_enable_o, .service_active_o, .irq_entry_i,
  .csr_push_o, .acc_valid_i, .acc_kind_i, .vaddr_i, .paddr_o, .paddr_valid_o);

// file: test/sae_core_model.sv
`timescale 1ns/1ps
module sae_core_model (
  // Clock
  input  wire logic                 clk_i,
  // Command from the bench
  input  wire logic                 go_i,
  input  wire sae_pkg::sae_acc_type kind_i,
  input  wire logic [15:0]          va_i,
  input  wire logic                 sel_i,
  // Request toward the translator
  output logic                      acc_valid_o = 1'b0,
  output sae_pkg::sae_acc_type      acc_kind_o = sae_pkg::ACC_FETCH,
  output logic [15:0]               vaddr_o = 16'h0000,
  output logic                      dma_segment_select_o = 1'b0
);
  // Idle address and select lines wander so a stale address is never taken for a live one
  always @(posedge clk_i) begin
    acc_valid_o <= go_i;
    acc_kind_o <= go_i ? kind_i : acc_kind_o;
    vaddr_o <= go_i ? va_i : ~vaddr_o;
    dma_segment_select_o <= go_i ? sel_i : ~dma_segment_select_o;
  end
endmodule : sae_core_model

// file: test/sae_top_test.sv
`timescale 1ns/1ps
module sae_top_test;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_page_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic reg_rvalid_o, page_reg_remap_o, code_seg_save_enable_o, service_active_o;
  logic irq_entry_i = 1'b0, iret_i = 1'b0, far_load_i = 1'b0, csr_restore_i = 1'b0;
  logic [5:0] far_seg_i = 6'h00, csr_restore_data_i = 6'h00, csr_push_data_o, cs, r;
  logic csr_push_o, acc_valid_i, dma_segment_select_i, paddr_valid_o, go = 1'b0, sel = 1'b0;
  sae_pkg::sae_acc_type acc_kind_i, kd = sae_pkg::ACC_FETCH;
  logic [15:0] vaddr_i, va = 16'h0000, vc = 16'h0000;
  logic [21:0] paddr_o, q_pa[$], q_rd[$], q_ps[$];
  logic [7:0] interrupt_segment, dsr, pg[4];
  logic [31:0] rs = 32'h2f7b;
  int n_mismatch = 0, checks_done = 0, cyc = 0;

  always #5 clk_i = ~clk_i;

  sae_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_page_i(reg_page_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .page_reg_remap_o(page_reg_remap_o),
    .code_seg_save_enable_o(code_seg_save_enable_o), .service_active_o(service_active_o),
    .irq_entry_i(irq_entry_i), .iret_i(iret_i), .far_load_i(far_load_i), .far_seg_i(far_seg_i),
    .csr_restore_i(csr_restore_i), .csr_restore_data_i(csr_restore_data_i), .csr_push_o(csr_push_o),
    .csr_push_data_o(csr_push_data_o), .acc_valid_i(acc_valid_i), .acc_kind_i(acc_kind_i),
    .vaddr_i(vaddr_i), .dma_segment_select_i(dma_segment_select_i), .paddr_o(paddr_o),
    .paddr_valid_o(paddr_valid_o));

  sae_core_model core_u (.clk_i(clk_i), .go_i(go), .kind_i(kd), .va_i(vc), .sel_i(sel),
    .acc_valid_o(acc_valid_i), .acc_kind_o(acc_kind_i), .vaddr_o(vaddr_i),
    .dma_segment_select_o(dma_segment_select_i));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task chk(input logic [21:0] e, input logic [21:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask : chk

  // An answer with no note behind it is as wrong as a wrong value
  task automatic take(ref logic [21:0] q[$], input logic [21:0] g);
    if (q.size() == 0) begin
      n_mismatch++;
      $display("mismatch at %0t exp none got %h", $time, g);
    end else
      chk(q.pop_front(), g);
  endtask : take

  task wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_page_i <= p;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] p, input logic ok, input logic [7:0] e);
    if (ok)
      q_rd.push_back({14'h0000, e});
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    reg_page_i <= p;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask : rd

  task acc(input sae_pkg::sae_acc_type k, input logic [15:0] v, input logic s, input logic [21:0] e);
    q_pa.push_back(e);
    @(posedge clk_i);
    go <= 1'b1;
    kd <= k;
    vc <= v;
    sel <= s;
    @(posedge clk_i);
    go <= 1'b0;
  endtask : acc

  // Event bits: entry, return, far load, restore
  task ev(input logic [3:0] m, input logic [5:0] d);
    @(posedge clk_i);
    {irq_entry_i, iret_i, far_load_i, csr_restore_i} <= m;
    far_seg_i <= d;
    csr_restore_data_i <= d;
    @(posedge clk_i);
    {irq_entry_i, iret_i, far_load_i, csr_restore_i} <= 4'h0;
  endtask : ev

  task automatic cmp_addr(input logic [21:0] g);
    take(q_pa, g);
  endtask : cmp_addr

  task automatic cmp_rdata(input logic [7:0] g);
    take(q_rd, {14'h0000, g});
  endtask : cmp_rdata

  task automatic cmp_push(input logic [5:0] g);
    take(q_ps, {16'h0000, g});
  endtask : cmp_push

  always @(posedge clk_i) begin
    if (paddr_valid_o === 1'b1)
      cmp_addr(paddr_o);
    if (reg_rvalid_o === 1'b1)
      cmp_rdata(reg_rdata_o);
    if (csr_push_o === 1'b1)
      cmp_push(csr_push_data_o);
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      $display("mismatch at %0t exp %h got %h", $time, 32'h0, cyc);
      end_sim();
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(8'hf4, 8'h15, 1'b1, 8'h00);
    rd(8'hf6, 8'h15, 1'b1, 8'h00);
    rs = xs(rs);
    va = rs[15:0];
    acc(sae_pkg::ACC_FETCH, va, 1'b0, {6'h00, va});
    rs = xs(rs);
    interrupt_segment = rs[7:0];
    dsr = rs[15:8];
    // Top bits forced high to show that they are dropped
    wr(8'hf8, 8'h15, interrupt_segment | 8'hc0);
    wr(8'hf9, 8'h15, dsr | 8'hc0);
    rd(8'hf8, 8'h15, 1'b1, {2'b00, interrupt_segment[5:0]});
    rd(8'hf9, 8'h15, 1'b1, {2'b00, dsr[5:0]});
    rd(8'hf5, 8'h15, 1'b0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      pg[i] = rs[7:0];
      wr(8'hf0 + 8'(i), 8'h15, pg[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      va = {2'(i), rs[13:0]};
      acc(sae_pkg::ACC_DATA, va, 1'b0, {pg[i], va[13:0]});
    end
    acc(sae_pkg::ACC_VECTOR, va, 1'b0, {interrupt_segment[5:0], va});
    acc(sae_pkg::ACC_DMA, va, 1'b0, {interrupt_segment[5:0], va});
    acc(sae_pkg::ACC_DMA, va, 1'b1, {dsr[5:0], va});
    rs = xs(rs);
    cs = rs[5:0];
    ev(4'b0010, cs);
    acc(sae_pkg::ACC_FETCH, va, 1'b0, {cs, va});
    ev(4'b1000, 6'h00);
    acc(sae_pkg::ACC_FETCH, va, 1'b0, {interrupt_segment[5:0], va});
    acc(sae_pkg::ACC_PROG_DATA, va, 1'b0, {interrupt_segment[5:0], va});
    acc(sae_pkg::ACC_DATA, {2'b01, va[13:0]}, 1'b0, {pg[1], va[13:0]});
    // Code segment is idle in a compatible service, so software may load it here
    rs = xs(rs);
    cs = rs[5:0];
    wr(8'hf4, 8'h15, {2'b00, cs});
    rd(8'hf4, 8'h15, 1'b1, {2'b00, cs});
    acc(sae_pkg::ACC_FETCH, va, 1'b0, {interrupt_segment[5:0], va});
    ev(4'b0101, ~cs);
    acc(sae_pkg::ACC_FETCH, va, 1'b0, {cs, va});
    wr(8'hf6, 8'h15, 8'h40);
    rd(8'hf6, 8'h15, 1'b1, 8'h40);
    q_ps.push_back({16'h0000, cs});
    ev(4'b1000, 6'h00);
    acc(sae_pkg::ACC_FETCH, va, 1'b0, {interrupt_segment[5:0], va});
    rs = xs(rs);
    r = rs[5:0];
    ev(4'b0101, r);
    acc(sae_pkg::ACC_FETCH, va, 1'b0, {r, va});
    wr(8'hf6, 8'h15, 8'h60);
    rd(8'hf6, 8'h15, 1'b1, 8'h60);
    rs = xs(rs);
    wr(8'he0, 8'h00, rs[7:0]);
    rd(8'he0, 8'h00, 1'b1, rs[7:0]);
    rd(8'hf0, 8'h15, 1'b0, 8'h00);
    acc(sae_pkg::ACC_DATA, {2'b00, va[13:0]}, 1'b0, {rs[7:0], va[13:0]});
    repeat (8) @(posedge clk_i);
    if (q_pa.size() + q_rd.size() + q_ps.size() != 0) begin
      n_mismatch++;
      $display("mismatch at %0t exp %h got %h", $time, 32'h0, q_pa.size() + q_rd.size() + q_ps.size());
    end
    end_sim();
  end
endmodule : sae_top_test
